/* hdl/acrb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module acrb_top #(
  parameter logic [6:0] DEFAULT_LOS_CODE = 7'h40
) (
  // system
  input wire logic CLK,
  input wire logic RST_N,
  // two-wire link
  input wire logic SCK,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  // disable pin; gates the link while the serial clock gate bit is set
  input wire logic DIS_PIN,
  // analog controls
  output acrb_pkg::acrb_ctrl_s CTRL
);

  function automatic logic dev_match(input logic [7:0] b);
    return b[7:1] == acrb_pkg::DEV_ADDR;
  endfunction

  function automatic logic [7:0] wmask(input logic [3:0] idx);
    case (idx)
      acrb_pkg::REG_CTRL: wmask = acrb_pkg::MASK_CTRL;
      acrb_pkg::REG_THR: wmask = acrb_pkg::MASK_THR;
      acrb_pkg::REG_CPDE: wmask = acrb_pkg::MASK_CPDE;
      acrb_pkg::REG_AMP: wmask = acrb_pkg::MASK_AMP;
      acrb_pkg::REG_RX_EQUALIZATION_CODE: wmask = acrb_pkg::MASK_RX_EQUALIZATION_CODE;
      acrb_pkg::REG_LOS_LEVEL_CODE: wmask = acrb_pkg::MASK_FULL;
      acrb_pkg::REG_FMASK: wmask = acrb_pkg::MASK_FULL;
      acrb_pkg::REG_RMASK: wmask = acrb_pkg::MASK_FULL;
      default: wmask = acrb_pkg::MASK_NONE;
    endcase
  endfunction

  // ---------------- system clock side ----------------
  logic link_rst_n_reg;
  logic gate_reg;
  logic [7:0] rd_word_reg;
  // ---------------- link clock side ----------------
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] rx_reg, rx_next;
  logic [1:0] byte_idx_reg, byte_idx_next;
  logic sel_reg, sel_next;
  logic read_reg, read_next;
  logic hold_s1_reg, hold_s2_reg;
  logic sda_oe_n_reg, sda_oe_n_next;
  logic [7:0] tx_reg, tx_next;
  logic [7:0] link_addr_reg, link_addr_next;
  logic [7:0] link_data_reg, link_data_next;
  logic addr_tgl_reg, addr_tgl_next;
  logic wr_tgl_reg, wr_tgl_next;

  // receive side: SDA is sampled on the rising SCK edge, as the protocol sets it up
  always_comb begin
    bit_cnt_next = bit_cnt_reg;
    rx_next = rx_reg;
    byte_idx_next = byte_idx_reg;
    sel_next = sel_reg;
    read_next = read_reg;
    if (bit_cnt_reg != acrb_pkg::ACK_SLOT) begin
      rx_next = {rx_reg[6:0], SDA_IN};
      bit_cnt_next = bit_cnt_reg + 4'h1;
    end else begin
      bit_cnt_next = 4'h0;
      if (byte_idx_reg != acrb_pkg::BYTE_EXTRA) begin
        byte_idx_next = byte_idx_reg + 2'h1;
      end
      if (byte_idx_reg == acrb_pkg::BYTE_DEV) begin
        sel_next = dev_match(rx_reg) && !hold_s2_reg;
        read_next = rx_reg[0];
      end
    end
  end

  // link state is cleared by every start and held clear between frames
  always_ff @(posedge SCK or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      byte_idx_reg <= acrb_pkg::BYTE_DEV;
      sel_reg <= 1'b0;
      read_reg <= 1'b0;
      hold_s1_reg <= 1'b0;
      hold_s2_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      rx_reg <= rx_next;
      byte_idx_reg <= byte_idx_next;
      sel_reg <= sel_next;
      read_reg <= read_next;
      hold_s1_reg <= gate_reg;
      hold_s2_reg <= hold_s1_reg;
    end
  end

  // drive side: acknowledge and read data change on the falling SCK edge
  always_comb begin
    sda_oe_n_next = 1'b1;
    tx_next = tx_reg;
    link_addr_next = link_addr_reg;
    link_data_next = link_data_reg;
    addr_tgl_next = addr_tgl_reg;
    wr_tgl_next = wr_tgl_reg;
    if (bit_cnt_reg == acrb_pkg::ACK_SLOT) begin
      unique case (byte_idx_reg)
        acrb_pkg::BYTE_DEV: begin
          sda_oe_n_next = !(dev_match(rx_reg) && !hold_s2_reg);
        end
        acrb_pkg::BYTE_REG: begin
          if (sel_reg && !read_reg) begin
            sda_oe_n_next = 1'b0;
            link_addr_next = rx_reg;
            addr_tgl_next = !addr_tgl_reg;
          end
        end
        acrb_pkg::BYTE_DATA: begin
          if (sel_reg && !read_reg) begin
            sda_oe_n_next = 1'b0;
            link_data_next = rx_reg;
            wr_tgl_next = !wr_tgl_reg;
          end
        end
        acrb_pkg::BYTE_EXTRA: begin
          sda_oe_n_next = 1'b1;
        end
      endcase
    end else if (sel_reg && read_reg && byte_idx_reg == acrb_pkg::BYTE_REG) begin
      tx_next = (bit_cnt_reg == 4'h0) ? rd_word_reg : {tx_reg[6:0], 1'b0};
      sda_oe_n_next = tx_next[7];
    end
  end

  always_ff @(negedge SCK or negedge link_rst_n_reg) begin
    if (!link_rst_n_reg) begin
      sda_oe_n_reg <= 1'b1;
      tx_reg <= 8'h00;
    end else begin
      sda_oe_n_reg <= sda_oe_n_next;
      tx_reg <= tx_next;
    end
  end

  // handed-over words and toggles survive starts and stops, so a frame edge never fakes a new word
  always_ff @(negedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      link_addr_reg <= 8'h00;
      link_data_reg <= 8'h00;
      addr_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
    end else begin
      link_addr_reg <= link_addr_next;
      link_data_reg <= link_data_next;
      addr_tgl_reg <= addr_tgl_next;
      wr_tgl_reg <= wr_tgl_next;
    end
  end

  // ---------------- system clock side ----------------
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic dis_s1_reg, dis_s2_reg;
  logic atg_s1_reg, atg_s2_reg, atg_s3_reg;
  logic wtg_s1_reg, wtg_s2_reg, wtg_s3_reg;

  // pin and toggle synchronisers; the toggles flag words that are already stable
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= 3'h7;
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= 3'h7;
      {dis_s1_reg, dis_s2_reg} <= 2'h0;
      {atg_s1_reg, atg_s2_reg, atg_s3_reg} <= 3'h0;
      {wtg_s1_reg, wtg_s2_reg, wtg_s3_reg} <= 3'h0;
    end else begin
      {scl_s1_reg, scl_s2_reg, scl_s3_reg} <= {SCK, scl_s1_reg, scl_s2_reg};
      {sda_s1_reg, sda_s2_reg, sda_s3_reg} <= {SDA_IN, sda_s1_reg, sda_s2_reg};
      {dis_s1_reg, dis_s2_reg} <= {DIS_PIN, dis_s1_reg};
      {atg_s1_reg, atg_s2_reg, atg_s3_reg} <= {addr_tgl_reg, atg_s1_reg, atg_s2_reg};
      {wtg_s1_reg, wtg_s2_reg, wtg_s3_reg} <= {wr_tgl_reg, wtg_s1_reg, wtg_s2_reg};
    end
  end

  logic start_det, stop_det, addr_evt, wr_evt;
  assign start_det = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
  assign stop_det = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;
  assign addr_evt = atg_s2_reg ^ atg_s3_reg;
  assign wr_evt = wtg_s2_reg ^ wtg_s3_reg;

  // framing: link reset pulses on each start, stays asserted after a stop
  logic frame_reg, frame_next, link_rst_n_next, gate_next;
  logic [7:0] regs_reg [acrb_pkg::NUM_REGS];
  always_comb begin
    frame_next = frame_reg;
    if (start_det) begin
      frame_next = 1'b1;
    end else if (stop_det) begin
      frame_next = 1'b0;
    end
    link_rst_n_next = frame_next && !start_det;
    gate_next = regs_reg[acrb_pkg::REG_CTRL][acrb_pkg::BIT_CLK_GATE] && dis_s2_reg;
  end

  logic sda_out_reg;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_reg <= 1'b0;
      link_rst_n_reg <= 1'b0;
      gate_reg <= 1'b0;
      sda_out_reg <= 1'b0;
    end else begin
      frame_reg <= frame_next;
      link_rst_n_reg <= link_rst_n_next;
      gate_reg <= gate_next;
      sda_out_reg <= 1'b0;
    end
  end

  // register bank
  logic [7:0] regs_next [acrb_pkg::NUM_REGS];
  logic [7:0] addr_q_reg, addr_q_next;
  logic [7:0] rd_word_next;
  acrb_pkg::acrb_ctrl_s ctrl_reg, ctrl_next;
  logic [6:0] active_level;
  always_comb begin
    regs_next = regs_reg;
    addr_q_next = addr_evt ? link_addr_reg : addr_q_reg;
    if (wr_evt && addr_q_reg[7:4] == 4'h0) begin
      regs_next[addr_q_reg[3:0]] = link_data_reg & wmask(addr_q_reg[3:0]);
    end
    active_level = regs_reg[acrb_pkg::REG_LOS_LEVEL_CODE][acrb_pkg::BIT_ENABLE] ?
                   regs_reg[acrb_pkg::REG_LOS_LEVEL_CODE][6:0] : DEFAULT_LOS_CODE;
    rd_word_next = 8'h00;
    if (addr_q_reg[7:4] == 4'h0) begin
      if (addr_q_reg[3:0] == acrb_pkg::REG_ACTIVE_LOS_LEVEL) begin
        rd_word_next = {1'b0, active_level};
      end else begin
        rd_word_next = regs_reg[addr_q_reg[3:0]] & wmask(addr_q_reg[3:0]);
      end
    end
    ctrl_next.serial_clock_gate = regs_reg[acrb_pkg::REG_CTRL][acrb_pkg::BIT_CLK_GATE];
    ctrl_next.output_invert = regs_reg[acrb_pkg::REG_CTRL][acrb_pkg::BIT_INVERT];
    ctrl_next.output_disable = regs_reg[acrb_pkg::REG_CTRL][acrb_pkg::BIT_DISABLE];
    ctrl_next.los_range_high = regs_reg[acrb_pkg::REG_CTRL][acrb_pkg::BIT_RANGE];
    ctrl_next.offset_cancel_off = regs_reg[acrb_pkg::REG_CTRL][acrb_pkg::BIT_OC_OFF];
    ctrl_next.threshold_shift_code = regs_reg[acrb_pkg::REG_THR];
    ctrl_next.threshold_off = regs_reg[acrb_pkg::REG_THR] == acrb_pkg::THR_OFF_CODE;
    ctrl_next.threshold_neg = regs_reg[acrb_pkg::REG_THR][7];
    if (regs_reg[acrb_pkg::REG_THR][7]) begin
      ctrl_next.threshold_mag = regs_reg[acrb_pkg::REG_THR][6:0];
    end else if (regs_reg[acrb_pkg::REG_THR] == acrb_pkg::THR_OFF_CODE) begin
      ctrl_next.threshold_mag = 7'h00;
    end else begin
      ctrl_next.threshold_mag = 7'(acrb_pkg::THR_ZERO_CODE - regs_reg[acrb_pkg::REG_THR]);
    end
    ctrl_next.crosspoint_range = regs_reg[acrb_pkg::REG_CPDE][5:4];
    ctrl_next.deemphasis_code = (regs_reg[acrb_pkg::REG_CPDE][3:0] > acrb_pkg::DEEMPH_MAX) ?
                                acrb_pkg::DEEMPH_MAX : regs_reg[acrb_pkg::REG_CPDE][3:0];
    ctrl_next.output_swing_code = regs_reg[acrb_pkg::REG_AMP][2:0];
    ctrl_next.rx_opt_enable = regs_reg[acrb_pkg::REG_RX_EQUALIZATION_CODE][acrb_pkg::BIT_ENABLE];
    ctrl_next.rx_equalization_code = ctrl_next.rx_opt_enable ?
                                     regs_reg[acrb_pkg::REG_RX_EQUALIZATION_CODE][3:2] : acrb_pkg::EQ_DEFAULT;
    ctrl_next.input_bias_boost = ctrl_next.rx_opt_enable &&
                                 regs_reg[acrb_pkg::REG_RX_EQUALIZATION_CODE][acrb_pkg::BIT_BIAS];
    ctrl_next.active_los_level = active_level;
    ctrl_next.fall_mask_enable = regs_reg[acrb_pkg::REG_FMASK][acrb_pkg::BIT_ENABLE];
    ctrl_next.fall_mask_time = regs_reg[acrb_pkg::REG_FMASK][6:0];
    ctrl_next.rise_mask_enable = regs_reg[acrb_pkg::REG_RMASK][acrb_pkg::BIT_ENABLE];
    ctrl_next.rise_mask_time = regs_reg[acrb_pkg::REG_RMASK][6:0];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < acrb_pkg::NUM_REGS; i++) begin
        regs_reg[i] <= (i == int'(acrb_pkg::REG_AMP)) ? acrb_pkg::RST_AMP : acrb_pkg::RST_ZERO;
      end
      addr_q_reg <= 8'h00;
      rd_word_reg <= 8'h00;
      ctrl_reg <= '0;
    end else begin
      regs_reg <= regs_next;
      addr_q_reg <= addr_q_next;
      rd_word_reg <= rd_word_next;
      ctrl_reg <= ctrl_next;
    end
  end

  assign SDA_OUT = sda_out_reg;
  assign SDA_OE_N = sda_oe_n_reg;
  assign CTRL = ctrl_reg;

  // ---------------- assertions ----------------
  AST_START_CLEARS_LINK: assert property (@(posedge CLK) disable iff (!RST_N)
    start_det |=> !link_rst_n_reg ##1 link_rst_n_reg)
    else $error("start did not pulse the link reset");
  AST_STOP_ENDS_FRAME: assert property (@(posedge CLK) disable iff (!RST_N)
    stop_det && !start_det |=> !frame_reg && !link_rst_n_reg)
    else $error("stop did not end the frame");
  AST_WRITE_LANDS: assert property (@(posedge CLK) disable iff (!RST_N)
    wr_evt && addr_q_reg == 8'h01 |=> regs_reg[acrb_pkg::REG_THR] == $past(link_data_reg))
    else $error("threshold write not stored");
  AST_ACTIVE_LOS_LEVEL_READ: assert property (@(posedge CLK) disable iff (!RST_N)
    addr_q_reg == 8'h0f && $stable(addr_q_reg) |=> rd_word_reg == {1'b0, $past(active_level)})
    else $error("read-only level readback wrong");
  AST_UNMAPPED_ZERO: assert property (@(posedge CLK) disable iff (!RST_N)
    addr_q_reg[7:4] != 4'h0 || addr_q_reg[3:0] == 4'he |=> rd_word_reg == 8'h00)
    else $error("unmapped address did not read zero");
  AST_CLOCK_GATE: assert property (@(posedge CLK) disable iff (!RST_N)
    regs_reg[acrb_pkg::REG_CTRL][acrb_pkg::BIT_CLK_GATE] && dis_s2_reg |=> gate_reg)
    else $error("serial clock gate not applied");
  AST_THR_OFF: assert property (@(posedge CLK) disable iff (!RST_N)
    regs_reg[acrb_pkg::REG_THR] == acrb_pkg::THR_OFF_CODE |=> ctrl_reg.threshold_off && ctrl_reg.threshold_mag == 7'h00)
    else $error("threshold off code not decoded");
  AST_THR_POS: assert property (@(posedge CLK) disable iff (!RST_N)
    regs_reg[acrb_pkg::REG_THR] != 8'h00 && !regs_reg[acrb_pkg::REG_THR][7] |=>
    !ctrl_reg.threshold_neg && ctrl_reg.threshold_mag == 7'($past(8'h80 - regs_reg[acrb_pkg::REG_THR])))
    else $error("positive threshold shift wrong");
  AST_RX_DEFAULT: assert property (@(posedge CLK) disable iff (!RST_N)
    !regs_reg[acrb_pkg::REG_RX_EQUALIZATION_CODE][7] |=> ctrl_reg.rx_equalization_code == 2'h0 && !ctrl_reg.input_bias_boost)
    else $error("receiver defaults not applied");
  AST_SWING_RESET: assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(RST_N) |-> ##1 ctrl_reg.output_swing_code == 3'h2)
    else $error("swing default not loaded");
  AST_EXTRA_NACK: assert property (@(negedge SCK) disable iff (!link_rst_n_reg)
    bit_cnt_reg == 4'h8 && byte_idx_reg == 2'h3 |=> sda_oe_n_reg)
    else $error("extra byte was acknowledged");
  AST_FOREIGN_ADDR: assert property (@(negedge SCK) disable iff (!link_rst_n_reg)
    bit_cnt_reg == 4'h8 && byte_idx_reg == 2'h0 && rx_reg[7:1] != 7'h44 |=> sda_oe_n_reg)
    else $error("foreign address acknowledged");
  COV_WRITE: cover property (@(posedge CLK) disable iff (!RST_N) wr_evt);
  COV_READ_LEVEL: cover property (@(posedge CLK) disable iff (!RST_N) addr_q_reg == 8'h0f && start_det);
  COV_GATED: cover property (@(posedge CLK) disable iff (!RST_N) gate_reg && start_det);
endmodule // acrb_top
`default_nettype wire

/* hdl/acrb_pkg.sv */
package acrb_pkg;
  // two-wire slave address
  localparam logic [6:0] DEV_ADDR = 7'h44;
  localparam int NUM_REGS = 16;
  // register indices (low nibble of the register address byte)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_THR = 4'h1;
  localparam logic [3:0] REG_CPDE = 4'h2;
  localparam logic [3:0] REG_AMP = 4'h3;
  localparam logic [3:0] REG_RX_EQUALIZATION_CODE = 4'h7;
  localparam logic [3:0] REG_LOS_LEVEL_CODE = 4'hb;
  localparam logic [3:0] REG_FMASK = 4'hc;
  localparam logic [3:0] REG_RMASK = 4'hd;
  localparam logic [3:0] REG_ACTIVE_LOS_LEVEL = 4'hf;
  // writable bits of each register
  localparam logic [7:0] MASK_CTRL = 8'h3e;
  localparam logic [7:0] MASK_THR = 8'hff;
  localparam logic [7:0] MASK_CPDE = 8'h3f;
  localparam logic [7:0] MASK_AMP = 8'h07;
  localparam logic [7:0] MASK_RX_EQUALIZATION_CODE = 8'h8d;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] MASK_NONE = 8'h00;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AMP = 8'h02;
  // field positions
  localparam int BIT_CLK_GATE = 5;
  localparam int BIT_INVERT = 4;
  localparam int BIT_DISABLE = 3;
  localparam int BIT_RANGE = 2;
  localparam int BIT_OC_OFF = 1;
  localparam int BIT_ENABLE = 7;
  localparam int BIT_BIAS = 0;
  // field codes
  localparam logic [7:0] THR_OFF_CODE = 8'h00;
  localparam logic [7:0] THR_ZERO_CODE = 8'h80;
  localparam logic [3:0] DEEMPH_MAX = 4'h8;
  localparam logic [1:0] EQ_DEFAULT = 2'h0;
  // link framing
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] BYTE_DEV = 2'h0;
  localparam logic [1:0] BYTE_REG = 2'h1;
  localparam logic [1:0] BYTE_DATA = 2'h2;
  localparam logic [1:0] BYTE_EXTRA = 2'h3;

  typedef struct packed {
    logic serial_clock_gate;
    logic output_invert;
    logic output_disable;
    logic los_range_high;
    logic offset_cancel_off;
    logic [7:0] threshold_shift_code;
    logic threshold_off;
    logic threshold_neg;
    logic [6:0] threshold_mag;
    logic [1:0] crosspoint_range;
    logic [3:0] deemphasis_code;
    logic [2:0] output_swing_code;
    logic rx_opt_enable;
    logic [1:0] rx_equalization_code;
    logic input_bias_boost;
    logic [6:0] active_los_level;
    logic fall_mask_enable;
    logic [6:0] fall_mask_time;
    logic rise_mask_enable;
    logic [6:0] rise_mask_time;
  } acrb_ctrl_s;
endpackage

/* verif/acrb_master.sv */
`timescale 1ns/1ps
`default_nettype none
module acrb_master (
  // bus lines
  output logic sck,
  output logic sda_drv,
  input wire logic sda_wire
);
  // quarter of the 125 ns link period
  localparam real Q = 31.25;
  initial begin
    sck = 1'b1;
    sda_drv = 1'b1;
  end
  // start or repeated start: sda falls while sck high
  task automatic start();
    sda_drv = 1'b1;
    #Q;
    sck = 1'b1;
    #(2 * Q);
    sda_drv = 1'b0;
    #(4 * Q);
    sck = 1'b0;
    #Q;
  endtask
  // stop, then idle long enough for the bank to settle
  task automatic stop();
    sda_drv = 1'b0;
    #Q;
    sck = 1'b1;
    #(2 * Q);
    sda_drv = 1'b1;
    #(12 * Q);
  endtask
  task automatic xfer(input logic b, output logic r);
    sda_drv = b;
    #Q;
    sck = 1'b1;
    r = sda_wire;
    #(2 * Q);
    sck = 1'b0;
    #Q;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
    end
    xfer(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(1'b1, d[i]);
    end
    // single byte is always answered with a nack
    xfer(1'b1, r);
  endtask
  // write frame, extra byte only on request
  task automatic wr(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] d, input logic extra,
                    output logic [3:0] acks);
    acks = 4'h0;
    start();
    send({dev, 1'b0}, acks[3]);
    send(ra, acks[2]);
    send(d, acks[1]);
    if (extra) begin
      send(d, acks[0]);
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] ra, output logic [7:0] d, output logic [2:0] acks);
    start();
    send({dev, 1'b0}, acks[2]);
    send(ra, acks[1]);
    start();
    send({dev, 1'b1}, acks[0]);
    recv(d);
    stop();
  endtask
endmodule // acrb_master
`default_nettype wire

/* verif/amp_control_register_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) check((got) !== (exp), 32'(got), 32'(exp))
module amp_control_register_bank_tb;
  localparam logic [6:0] LOS_DEF = 7'h25; // arbitrary fixed loss level
  localparam logic [7:0] RA[8] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h0b, 8'h0c, 8'h0d};
  localparam logic [7:0] RM[8] = '{8'h3e, 8'hff, 8'h3f, 8'h07, 8'h8d, 8'hff, 8'hff, 8'hff};
  localparam logic [7:0] TH[6] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'h81, 8'hff};
  // expected {off, negative, magnitude} for each threshold code
  localparam logic [8:0] TE[6] = '{9'h100, 9'h07f, 9'h001, 9'h080, 9'h081, 9'h0ff};
  localparam logic [7:0] RX[4] = '{8'h81, 8'h85, 8'h05, 8'h8c};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dis_pin = 1'b0;
  logic sck, sda_drv, sda_out, sda_oe_n, sda_wire;
  logic [3:0] a;
  acrb_pkg::acrb_ctrl_s ctrl;
  int compares = 0;
  int err_count = 0;
  always #5 clk = ~clk;
  // open-drain wire with pull-up
  assign sda_wire = sda_drv & (sda_oe_n | sda_out);
  acrb_top #(.DEFAULT_LOS_CODE(LOS_DEF)) dut (.CLK(clk), .RST_N(rst_n), .SCK(sck), .SDA_IN(sda_wire),
    .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .DIS_PIN(dis_pin), .CTRL(ctrl));
  acrb_master mst (.sck(sck), .sda_drv(sda_drv), .sda_wire(sda_wire));
  task automatic check(input bit bad, input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (bad) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] ra, input logic [7:0] d);
    logic [3:0] k;
    mst.wr(acrb_pkg::DEV_ADDR, ra, d, 1'b0, k);
    `CHK(k, 4'he);
  endtask
  task automatic rd_chk(input logic [7:0] ra, input logic [7:0] e);
    logic [7:0] d;
    logic [2:0] k;
    mst.rd(acrb_pkg::DEV_ADDR, ra, d, k);
    `CHK(k, 3'h7);
    `CHK(d, e);
  endtask
  task automatic t_reset();
    `CHK(ctrl.output_swing_code, 3'h2);
    `CHK(ctrl.active_los_level, LOS_DEF);
    rd_chk(8'h03, 8'h02);
    rd_chk(8'h0c, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_rw();
    for (int i = 0; i < 8; i++) begin
      wr(RA[i], 8'hff);
      rd_chk(RA[i], RM[i]);
      wr(RA[i], 8'h00);
      rd_chk(RA[i], 8'h00);
    end
    $display("test readwrite done");
  endtask
  task automatic t_ctrl();
    for (int b = 1; b <= 5; b++) begin
      wr(8'h00, 8'(1 << b));
      `CHK({ctrl.serial_clock_gate, ctrl.output_invert, ctrl.output_disable, ctrl.los_range_high,
            ctrl.offset_cancel_off}, 5'(1 << (b - 1)));
    end
    wr(8'h00, 8'h01);
    rd_chk(8'h00, 8'h00);
    $display("test control done");
  endtask
  task automatic t_thr();
    for (int i = 0; i < 6; i++) begin
      wr(8'h01, TH[i]);
      `CHK({ctrl.threshold_off, ctrl.threshold_neg, ctrl.threshold_mag}, TE[i]);
    end
    $display("test threshold done");
  endtask
  task automatic t_fields();
    logic [7:0] v;
    wr(8'h02, 8'h38);
    `CHK({ctrl.crosspoint_range, ctrl.deemphasis_code}, 6'h38);
    wr(8'h02, 8'h1f);
    `CHK({ctrl.crosspoint_range, ctrl.deemphasis_code}, 6'h18);
    rd_chk(8'h02, 8'h1f);
    for (int c = 0; c < 8; c++) begin
      wr(8'h03, 8'(c));
      `CHK(ctrl.output_swing_code, 3'(c));
    end
    for (int i = 0; i < 4; i++) begin
      v = RX[i];
      wr(8'h07, v);
      `CHK({ctrl.rx_opt_enable, ctrl.rx_equalization_code, ctrl.input_bias_boost},
           {v[7], v[7] ? v[3:2] : 2'h0, v[7] & v[0]});
    end
    $display("test fields done");
  endtask
  task automatic t_los();
    wr(8'h0b, 8'h00);
    `CHK(ctrl.active_los_level, LOS_DEF);
    rd_chk(8'h0f, {1'b0, LOS_DEF});
    wr(8'h0b, 8'h9a);
    `CHK(ctrl.active_los_level, 7'h1a);
    mst.wr(acrb_pkg::DEV_ADDR, 8'h0f, 8'hff, 1'b0, a);
    rd_chk(8'h0f, 8'h1a);
    wr(8'h0c, 8'h85);
    `CHK({ctrl.fall_mask_enable, ctrl.fall_mask_time}, 8'h85);
    wr(8'h0d, 8'h7f);
    `CHK({ctrl.rise_mask_enable, ctrl.rise_mask_time}, 8'h7f);
    wr(8'h0d, 8'h80);
    `CHK({ctrl.rise_mask_enable, ctrl.rise_mask_time}, 8'h80);
    $display("test loss done");
  endtask
  task automatic t_refuse();
    mst.wr(7'h45, 8'h01, 8'h55, 1'b0, a);
    `CHK(a[3], 1'b0);
    rd_chk(8'h01, 8'hff);
    mst.wr(acrb_pkg::DEV_ADDR, 8'h01, 8'h33, 1'b1, a);
    `CHK(a, 4'he);
    rd_chk(8'h01, 8'h33);
    mst.wr(acrb_pkg::DEV_ADDR, 8'h05, 8'hff, 1'b0, a);
    rd_chk(8'h05, 8'h00);
    mst.wr(acrb_pkg::DEV_ADDR, 8'h1d, 8'h11, 1'b0, a);
    rd_chk(8'h0d, 8'h80);
    rd_chk(8'h1d, 8'h00);
    $display("test refuse done");
  endtask
  task automatic t_gate();
    wr(8'h00, 8'h20);
    @(negedge clk);
    dis_pin = 1'b1;
    repeat (5) @(negedge clk);
    mst.wr(acrb_pkg::DEV_ADDR, 8'h01, 8'h77, 1'b0, a);
    `CHK(a[3], 1'b0);
    @(negedge clk);
    dis_pin = 1'b0;
    repeat (5) @(negedge clk);
    rd_chk(8'h01, 8'h33);
    wr(8'h00, 8'h00);
    $display("test gate done");
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_rw();
    t_ctrl();
    t_thr();
    t_fields();
    t_los();
    t_refuse();
    t_gate();
    stop_test();
  end
  initial begin
    #900us;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule // amp_control_register_bank_tb
`default_nettype wire
